// ### mbx_engine.sv
/*
  mailbox engine: decodes a request, starts the slave service unless the request is refused, writes
  the whole 128-word response area one word per cycle, then signals done.
  assumes req and slave result are steady from their strobes onward and
  come from logic on clk.
*/
`timescale 1ns/1ns
`default_nettype none
// Function
// R1: successful initiate writes success code into response word zero.
// R2: word one holds station address low byte, connection reference high.
// R3: returned connection reference lies within zero to 126.
// R4: words two to five pass slave length, features, profile fields through.
// R5: word six holds source type low byte, source length high byte.
// R6: word seven holds destination type low, destination length high.
// R7: success response words eight to 127 are zero.
// R8: failure puts error code in word zero, keeps word one.
// R9: words two to four detail codes on slave-negative, else all ones; refused requests get zero there.
// R10: failed response words five to 127 are zero.
// R11: host writes abort request code into request word zero.
// R12: abort word one low byte holds target station, zero to 125.
// R13: abort word one high byte holds initiate connection reference.
// R14: abort word two low byte is instance reason, zero.
// R15: abort word two high byte is fixed subnet constant.
// R16: host zeroes abort request words three to 127.
// R17: decode word zero code; fill whole response before done.
module mbx_engine
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire mbx_pkg::req_s req,
  output logic svc_start,
  output logic svc_abort,
  input wire logic res_valid,
  input wire mbx_pkg::slave_res_s res,
  output logic resp_we,
  output logic [6:0] resp_idx,
  output logic [15:0] resp_data,
  output logic done
);
  import mbx_pkg::*;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // ----------------------------------------
  // word builder
  // ----------------------------------------
  function automatic logic [15:0] word_at(input logic [6:0] idx,
    input logic is_abort, input logic bad, input slave_res_s r,
    input req_s q);
    logic [15:0] w;
    logic neg;
    w = WORD_ZERO;
    neg = (r.err_code == CODE_SLAVE_NEG);
    if (idx == IDX_CODE)
    begin
      if (bad)
        w = CODE_BAD_REQ;
      else if (r.ok)
        w = is_abort ? CODE_ABORT_OK : CODE_INITIATE_OK; // R1
      else
        w = r.err_code; // R8
    end
    else if (idx == IDX_ADDR)
      w = {(r.cref > CREF_MAX) ? CREF_MAX : r.cref, q.station}; // R2 R3 R8
    else if (!is_abort && r.ok)
    begin
      unique case (idx)
        IDX_MAX_LEN: w = r.max_len; // R4
        IDX_FEATURES: w = r.features; // R4
        IDX_PROF_FEAT: w = r.prof_features; // R4
        IDX_PROF_IDENT: w = r.prof_ident; // R4
        IDX_SRC: w = {r.src_len, r.src_type}; // R5
        IDX_DST: w = {r.dst_len, r.dst_type}; // R6
        default: w = WORD_ZERO; // R7
      endcase
    end
    else if (!r.ok && !bad)
    begin
      unique case (idx)
        IDX_DETAIL1: w = neg ? r.detail1 : NO_DETAIL; // R9
        IDX_DETAIL2: w = neg ? r.detail2 : NO_DETAIL; // R9
        IDX_DETAIL3: w = neg ? r.detail3 : NO_DETAIL; // R9
        default: w = WORD_ZERO; // R10
      endcase
    end
    return w;
  endfunction

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  mbx_state_e state;
  logic is_abort;
  logic bad;
  logic [6:0] idx;
  req_s q;
  slave_res_s r;
  logic code_init;
  logic code_abort;
  logic abort_ok;
  assign code_init = (req.code == CODE_INITIATE_REQ);
  assign code_abort = (req.code == CODE_ABORT_REQ); // R11
  // refused aborts must never reach the slave side
  assign abort_ok = code_abort && req.station <= STATION_MAX // R12
    && req.cref <= CREF_MAX // R13
    && req.reason == ABORT_REASON // R14
    && req.subnet == ABORT_SUBNET; // R15

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= IDLE;
      is_abort <= 1'b0;
      bad <= 1'b0;
      idx <= IDX_CODE;
      q <= '0;
      r <= '0;
      svc_start <= 1'b0;
      svc_abort <= 1'b0;
      resp_we <= 1'b0;
      resp_idx <= IDX_CODE;
      resp_data <= WORD_ZERO;
      done <= 1'b0;
    end
    else
    begin
      svc_start <= 1'b0;
      resp_we <= 1'b0;
      done <= 1'b0;
      unique case (state)
        IDLE:
        begin
          if (req_valid)
          begin
            q <= req;
            is_abort <= code_abort; // R17
            bad <= !(code_init || abort_ok);
            r <= '0;
            svc_abort <= abort_ok;
            if (code_init || abort_ok)
              svc_start <= 1'b1; // R17
            state <= (code_init || abort_ok) ? WAIT : FILL;
            idx <= IDX_CODE;
          end
        end
        WAIT:
        begin
          if (res_valid)
          begin
            r <= res;
            state <= FILL;
          end
        end
        FILL:
        begin
          resp_we <= 1'b1;
          resp_idx <= idx;
          resp_data <= word_at(idx, is_abort, bad, r, q);
          idx <= idx + 7'h01;
          if (idx == IDX_LAST)
            state <= DONE; // R17
        end
        DONE:
        begin
          done <= 1'b1; // R17
          state <= IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  ok_code_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
    resp_we && resp_idx == IDX_CODE && r.ok && !bad && !is_abort
    |-> resp_data == CODE_INITIATE_OK)
    else $error("initiate success code wrong");
  addr_word_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
    resp_we && resp_idx == IDX_ADDR |-> resp_data[7:0] == q.station)
    else $error("station byte wrong");
  cref_range_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
    resp_we && resp_idx == IDX_ADDR |-> resp_data[15:8] <= CREF_MAX)
    else $error("connection reference out of range");
  src_word_a: assert property (@(posedge clk) disable iff (!rst_n) // R5
    resp_we && resp_idx == IDX_SRC && r.ok && !bad && !is_abort
    |-> resp_data == {r.src_len, r.src_type})
    else $error("source word wrong");
  dst_word_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
    resp_we && resp_idx == IDX_DST && r.ok && !bad && !is_abort
    |-> resp_data == {r.dst_len, r.dst_type})
    else $error("destination word wrong");
  tail_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // R7
    resp_we && resp_idx >= IDX_OK_TAIL |-> resp_data == WORD_ZERO)
    else $error("tail not zero");
  fail_code_a: assert property (@(posedge clk) disable iff (!rst_n) // R8
    resp_we && resp_idx == IDX_CODE && !r.ok && !bad
    |-> resp_data == r.err_code)
    else $error("error code wrong");
  detail_ones_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
    resp_we && resp_idx == IDX_DETAIL1 && !r.ok && !bad
    && r.err_code != CODE_SLAVE_NEG |-> resp_data == NO_DETAIL)
    else $error("detail word not all ones");
  fail_tail_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
    resp_we && resp_idx == IDX_FAIL_TAIL && !r.ok
    |-> resp_data == WORD_ZERO)
    else $error("failed word five not zero");
  done_after_a: assert property (@(posedge clk) disable iff (!rst_n) // R17
    resp_we && resp_idx == IDX_LAST |=> done)
    else $error("done not after last word");
  start_ok_a: assert property (@(posedge clk) disable iff (!rst_n) // R17
    svc_start |-> !bad)
    else $error("service started for refused request");
endmodule // mbx_engine
`default_nettype wire

// ### mbx_pkg.sv
/*
  shared constants and carriers for the class-2 initiate/abort mailbox.
  assumes a 16-bit word-wide response area of 128 words.
*/
package mbx_pkg;
  localparam int WORD_W = 16;
  localparam int AREA_WORDS = 128;
  localparam int IDX_W = 7;
  localparam logic [15:0] CODE_INITIATE_REQ = 16'h1412;
  localparam logic [15:0] CODE_ABORT_REQ = 16'h1413;
  localparam logic [15:0] CODE_INITIATE_OK = 16'hA412;
  localparam logic [15:0] CODE_ABORT_OK = 16'hA413;
  localparam logic [15:0] CODE_SLAVE_NEG = 16'hE482;
  localparam logic [15:0] CODE_BAD_REQ = 16'hE401;
  localparam logic [15:0] NO_DETAIL = 16'hFFFF;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] STATION_MAX = 8'h7D;
  localparam logic [7:0] CREF_MAX = 8'h7E;
  localparam logic [7:0] ABORT_REASON = 8'h00;
  localparam logic [7:0] ABORT_SUBNET = 8'h30;
  localparam logic [6:0] IDX_LAST = 7'h7F;
  localparam logic [6:0] IDX_CODE = 7'h00;
  localparam logic [6:0] IDX_ADDR = 7'h01;
  localparam logic [6:0] IDX_MAX_LEN = 7'h02;
  localparam logic [6:0] IDX_FEATURES = 7'h03;
  localparam logic [6:0] IDX_PROF_FEAT = 7'h04;
  localparam logic [6:0] IDX_PROF_IDENT = 7'h05;
  localparam logic [6:0] IDX_SRC = 7'h06;
  localparam logic [6:0] IDX_DST = 7'h07;
  localparam logic [6:0] IDX_OK_TAIL = 7'h08;
  localparam logic [6:0] IDX_DETAIL1 = 7'h02;
  localparam logic [6:0] IDX_DETAIL2 = 7'h03;
  localparam logic [6:0] IDX_DETAIL3 = 7'h04;
  localparam logic [6:0] IDX_FAIL_TAIL = 7'h05;

  // request as the host left it in the request area
  typedef struct packed {
    logic [15:0] code;
    logic [7:0] cref;
    logic [7:0] station;
    logic [7:0] subnet;
    logic [7:0] reason;
  } req_s;

  // result delivered by the slave-side engine
  typedef struct packed {
    logic ok;
    logic [15:0] err_code;
    logic [7:0] cref;
    logic [15:0] max_len;
    logic [15:0] features;
    logic [15:0] prof_features;
    logic [15:0] prof_ident;
    logic [7:0] src_type;
    logic [7:0] src_len;
    logic [7:0] dst_type;
    logic [7:0] dst_len;
    logic [15:0] detail1;
    logic [15:0] detail2;
    logic [15:0] detail3;
  } slave_res_s;

  typedef enum logic [1:0] {
    IDLE = 2'b00,
    WAIT = 2'b01,
    FILL = 2'b10,
    DONE = 2'b11
  } mbx_state_e;
endpackage

// ### slave_model.sv
/*
  slave-side engine model: answers each started service after a set delay.
  assumes the start strobe is registered on clk.
*/
`timescale 1ns/1ns
`default_nettype none
module slave_model
  import mbx_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic svc_start,
  input wire mbx_pkg::slave_res_s res_set,
  input wire logic [7:0] lat,
  output logic res_valid,
  output mbx_pkg::slave_res_s res
);
  int cnt;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt <= 0;
      res_valid <= 1'b0;
      res <= '0;
    end
    else if (svc_start)
    begin
      cnt <= int'(lat) + 1;
      res <= ~res_set;
    end
    else if (cnt == 1)
    begin
      res <= res_set;
      res_valid <= 1'b1;
      cnt <= 0;
    end
    else
    begin
      res_valid <= 1'b0;
      if (cnt > 1)
        cnt <= cnt - 1;
    end
  end
endmodule // slave_model
`default_nettype wire

// ### tb.sv
/*
  testbench: host requests against the mailbox engine, checked word by word.
  assumes slave_model stands at the service side.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  n_errors++; $display("wrong value t=%0t got %h exp %h", $time, a, b); \
  end end
module tb;
  import mbx_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, req_valid = 1'b0, res_valid;
  logic svc_start, svc_abort, resp_we, done;
  logic [6:0] resp_idx;
  logic [15:0] resp_data;
  logic [7:0] lat = 8'h00;
  req_s req = '0;
  slave_res_s res, res_set = '0, r;
  req_s q;
  logic [191:0] rnd;
  int n_errors = 0, samples_checked = 0;
  always #2 clk = ~clk;
  mbx_engine i_dut (.clk(clk), .arst_n(arst_n), .req_valid(req_valid),
    .req(req), .svc_start(svc_start), .svc_abort(svc_abort),
    .res_valid(res_valid), .res(res), .resp_we(resp_we),
    .resp_idx(resp_idx), .resp_data(resp_data), .done(done));
  slave_model i_slave (.clk(clk), .arst_n(arst_n), .svc_start(svc_start),
    .res_set(res_set), .lat(lat), .res_valid(res_valid), .res(res));
  // ----------------------------------------
  // expected response word
  // ----------------------------------------
  function automatic logic [15:0] exp_w(int i, req_s a, slave_res_s s);
    logic ab, bad;
    logic [7:0] c;
    ab = a.code == 16'h1413;
    bad = !(ab || a.code == 16'h1412) || (ab && (a.station > 8'h7D ||
      a.cref > 8'h7E || a.reason != 8'h00 || a.subnet != 8'h30));
    c = bad ? 8'h00 : (s.cref > 8'h7E ? 8'h7E : s.cref);
    if (i == 1)
      return {c, a.station};
    if (bad)
      return i == 0 ? 16'hE401 : 16'h0000;
    if (!s.ok)
    begin
      if (i == 0)
        return s.err_code;
      if (i > 4)
        return 16'h0000;
      if (s.err_code != 16'hE482)
        return 16'hFFFF;
      return i == 2 ? s.detail1 : (i == 3 ? s.detail2 : s.detail3);
    end
    if (ab)
      return i == 0 ? 16'hA413 : 16'h0000;
    case (i)
      0: return 16'hA412;
      2: return s.max_len;
      3: return s.features;
      4: return s.prof_features;
      5: return s.prof_ident;
      6: return {s.src_len, s.src_type};
      7: return {s.dst_len, s.dst_type};
      default: return 16'h0000;
    endcase
  endfunction
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // one request, all 128 words collected
  task automatic run(req_s a, slave_res_s s);
    int w;
    w = 0;
    res_set <= s;
    lat <= 8'($urandom_range(0, 20));
    req <= a;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    @(posedge clk);
    `CHK(svc_start, exp_w(0, a, s) != 16'hE401)
    if (svc_start === 1'b1)
      `CHK(svc_abort, a.code == 16'h1413)
    for (int k = 0; k < 400; k++)
    begin
      if (k == 1)
        req_valid <= 1'b1;
      if (k == 2)
        req_valid <= 1'b0;
      if (resp_we === 1'b1)
      begin
        `CHK(resp_idx, 7'(w))
        `CHK(resp_data, exp_w(w, a, s))
        w++;
      end
      if (done === 1'b1)
        break;
      @(posedge clk);
    end
    `CHK(done, 1'b1)
    `CHK(w, 128)
  endtask
  initial
  begin
    #240000;
    n_errors++;
    close_out;
  end
  initial
  begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    void'($urandom(32'h63f4));
    for (int t = 0; t < 12; t++)
    begin
      q = '0;
      rnd = {$urandom(), $urandom(), $urandom(), $urandom(), $urandom(),
        $urandom()};
      r = rnd[168:0];
      q.code = (t < 5 || t == 8) ? 16'h1412 : 16'h1413;
      q.station = t == 5 ? 8'h7D : 8'($urandom_range(0, 125));
      q.cref = 8'($urandom_range(0, 126));
      q.reason = t == 11 ? 8'h01 : 8'h00;
      q.subnet = t == 10 ? 8'h31 : 8'h30;
      r.ok = t == 0 || t == 1 || t == 5;
      r.err_code = t % 2 == 0 ? 16'hE482 : 16'hE4A0;
      if (t == 1)
        r.cref = 8'h90;
      if (t >= 5)
        r.cref = q.cref;
      if (t == 8)
        q.code = 16'h1234;
      if (t == 9)
        q.station = 8'h7E;
      run(q, r);
    end
    close_out;
  end
endmodule // tb
`default_nettype wire
